// file: ppc_pkg.sv
// Purpose: Shared constants and types for the postprocessor config control.
// Assumes: One 100 MHz clock for both ends of the link.
// Notes:   Source-select encoding and instruction codes are local choices.
package ppc_pkg;
   // =========================================================
   // Widths and codes
   localparam int          DATA_W           = 16;
   localparam logic [15:0] INSTR_CONFIGURE  = 16'h0001;
   localparam logic [15:0] INSTR_START      = 16'h0002;
   typedef enum logic [1:0] {
      SRC_EPROM, SRC_DSP, SRC_ROM, SRC_ROM_ALT
   } ppc_src_t;
   // =========================================================
   // Timing counts (clock cycles), config sizes (bits, words) and settling results
   localparam logic [3:0]  ROM_PULSE_CYCLES = 4'h8;
   localparam logic [1:0]  STRAP_WAIT       = 2'h3;
   localparam int          CFG_BITS_DEF     = 64;
   localparam int          CFG_WORDS_DEF    = 8;
   localparam int          ROM_LEN_DEF      = 32;
   localparam int          DECIM_DEF        = 16;
   localparam logic [7:0]  SETTLE_RESULTS   = 8'h04;
   localparam logic [3:0]  CS_LOW_CYCLES    = 4'h6;
   localparam logic [3:0]  BIT_HALF_CYCLES  = 4'h3;
   localparam logic [3:0]  CFG_RST_CYCLES   = 4'h4;
   localparam logic [7:0]  RESTART_GAP      = 8'h20;
   // =========================================================
   // Status word bit positions
   localparam int          STAT_DONE        = 0;
   localparam int          STAT_PARTIAL     = 1;
   localparam int          STAT_RUN         = 2;
   localparam int          STAT_LOW_POWER   = 3;
   localparam int          STAT_PAR         = 4;
endpackage

// file: ppc_link_if.sv
// Purpose: Pin-level link between the converter and its host.
// Assumes: Data bus resolved here from the two output enables.
// Notes:   No driver gives bus value zero.
`timescale 1ns/1ps
interface ppc_link_if;
   logic        low_power_request;
   logic        filter_restart;
   logic        config_restart_pin_n;
   logic        frame_sync_in;
   logic        config_handshake_out;
   logic        config_done_flag;
   logic        select_n;
   logic        read_not_write;
   logic        register_select_in;
   logic        source_select_hi;
   logic        source_select_lo;
   logic        parallel_mode;
   logic        cfg_bit;
   logic        cfg_strobe;
   logic [15:0] dev_dout;
   logic        dev_oe;
   logic [15:0] host_dout;
   logic        host_oe;
   logic [15:0] bus;
   assign bus = dev_oe ? dev_dout : (host_oe ? host_dout : 16'h0000);
   modport dev (
      input  low_power_request, filter_restart, config_restart_pin_n,
      input  frame_sync_in, select_n, read_not_write, register_select_in,
      input  source_select_hi, source_select_lo, parallel_mode,
      input  cfg_bit, cfg_strobe, bus,
      output config_handshake_out, config_done_flag, dev_dout, dev_oe
   );
   modport host (
      output low_power_request, filter_restart, config_restart_pin_n,
      output frame_sync_in, select_n, read_not_write, register_select_in,
      output source_select_hi, source_select_lo, parallel_mode,
      output cfg_bit, cfg_strobe, host_dout, host_oe,
      input  config_handshake_out, config_done_flag, bus
   );
endinterface

// file: ppc_sync2.sv
// Purpose: Two-flop synchroniser for pin inputs.
// Assumes: Inputs change at most once per two cycles for edge use.
// Notes:   Reset value per bit set by INIT.
`timescale 1ns/1ps
module ppc_sync2 #(
   parameter int         W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         i_clk_sys,
   input  wire logic         i_reset_n,
   input  wire logic [W-1:0] i_async,
   output      logic [W-1:0] o_sync
);
   logic [W-1:0] meta;
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         meta   <= INIT;
         o_sync <= INIT;
      end else begin
         meta   <= i_async;
         o_sync <= meta;
      end
   end
endmodule // ppc_sync2

// file: ppc_device.sv
// Purpose: Converter-side control: standby, restart, config load, bus.
// Assumes: All link inputs are asynchronous and pass ppc_sync2 first.
// Notes:   Conversion data is a stand-in count per decimation period.
// Notes on behaviour
// - High low-power request enters standby
// - Completed configuration kept through standby
// - Low request leaves standby
// - Partial config restarts in serial modes
// - Parallel host reissues configure after partial
// - Configured serial modes resume converting automatically
// - Configured parallel mode waits start instruction
// - Host keeps master clock running
// - Restart holds sequencer zero, core reset
// - After restart, results valid post settling
// - Host must not pulse restart continuously
// - Shared restart aligns sampling across devices
// - EPROM mode: enable low, resets address
// - DSP: handshake high after reset, restart
// - DSP: handshake high after successful config
// - DSP: frame sync high clears handshake
// - ROM boot: handshake high eight cycles
// - Select fall drives data or status
// - Select rise captures data or instruction
// - Upper select bit chooses serial source
// - Source straps sampled once after power-up
// - Serial: done flag after clean programming
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module ppc_device
   import ppc_pkg::*;
#(
   parameter int CFG_BITS  = ppc_pkg::CFG_BITS_DEF,
   parameter int CFG_WORDS = ppc_pkg::CFG_WORDS_DEF,
   parameter int ROM_LEN   = ppc_pkg::ROM_LEN_DEF,
   parameter int DECIM     = ppc_pkg::DECIM_DEF
) (
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset_n,
   ppc_link_if.dev          link,
   output      logic [15:0] o_result,
   output      logic        o_result_valid,
   output      logic        o_configured,
   output      logic        o_low_power,
   output      logic        o_core_reset
);
   import ppc_pkg::*;
   typedef enum logic [2:0] {
      ST_STRAP, ST_BOOT, ST_IDLE, ST_LOAD, ST_READY, ST_RUN, ST_LOW_POWER_REQUEST
   } ppc_dev_st_t;
   typedef struct packed {
      ppc_dev_st_t st;
      logic        par;
      ppc_src_t    src;
      logic [1:0]  strap_cnt;
      logic        done;
      logic        partial;
      logic        hs;
      logic [3:0]  hs_cnt;
      logic [15:0] cfg_cnt;
      logic [15:0] seq_cnt;
      logic [7:0]  settle;
      logic [15:0] result;
      logic        res_valid;
      logic        core_rst;
      logic [15:0] rdata;
      logic        oe;
      logic        cs_q;
      logic        strobe_q;
      logic        rst_q;
      logic [15:0] bus_q;
   } ppc_dev_regs_t;

   // ==========================================================
   // Pin synchronisers
   localparam logic [27:0] SYNC_INIT = 28'h0000014;
   logic [27:0] s;
   logic        s_lp, s_restart, s_cfgrst_n, s_fsync, s_cs_n, s_rnw, s_rs;
   logic        s_hi, s_lo, s_par, s_bit, s_strobe;
   logic [15:0] s_bus;
   ppc_sync2 #(.W(28), .INIT(SYNC_INIT)) u_sync (
      .i_clk_sys (i_clk_sys),
      .i_reset_n (i_reset_n),
      .i_async   ({link.bus, link.cfg_strobe, link.cfg_bit,
                   link.parallel_mode, link.source_select_lo,
                   link.source_select_hi, link.register_select_in,
                   link.read_not_write, link.select_n,
                   link.frame_sync_in, link.config_restart_pin_n,
                   link.filter_restart, link.low_power_request}),
      .o_sync    (s)
   );
   assign {s_bus, s_strobe, s_bit, s_par, s_lo, s_hi, s_rs, s_rnw,
           s_cs_n, s_fsync, s_cfgrst_n, s_restart, s_lp} = s;

   // ==========================================================
   // Next-state logic
   ppc_dev_regs_t r;
   ppc_dev_regs_t next_r;
   logic          cs_fall, cs_rise, bit_take, cfg_rst, last_cfg;
   logic [15:0]   status;

   assign cs_fall  = r.cs_q & ~s_cs_n;
   assign cs_rise  = ~r.cs_q & s_cs_n;
   assign bit_take = s_strobe & ~r.strobe_q;
   assign cfg_rst  = r.rst_q & ~s_cfgrst_n;
   assign last_cfg = r.par ? (r.cfg_cnt == 16'(CFG_WORDS - 1))
                   : (r.src[1] ? (r.cfg_cnt == 16'(ROM_LEN - 1))
                   : (r.cfg_cnt == 16'(CFG_BITS - 1)));

   always_comb begin
      status                 = 16'h0000;
      status[STAT_DONE]      = r.done;
      status[STAT_PARTIAL]   = r.partial;
      status[STAT_RUN]       = (r.st == ST_RUN);
      status[STAT_LOW_POWER] = (r.st == ST_LOW_POWER_REQUEST);
      status[STAT_PAR]       = r.par;
   end

   always_comb begin
      next_r           = r;
      next_r.res_valid = 1'b0;
      next_r.cs_q      = s_cs_n;
      next_r.strobe_q  = s_strobe;
      next_r.rst_q     = s_cfgrst_n;
      next_r.bus_q     = s_bus;
      next_r.core_rst  = s_restart;
      if (r.hs_cnt != 4'h0) begin
         next_r.hs_cnt = r.hs_cnt - 4'h1;
         if (r.hs_cnt == 4'h1) begin
            next_r.hs = 1'b0;
         end
      end
      if (!r.par && r.src == SRC_DSP && s_fsync) begin
         next_r.hs = 1'b0;
      end
      // Parallel bus read drive and release
      if (r.par && cs_fall && s_rnw) begin
         next_r.oe    = 1'b1;
         next_r.rdata = s_rs ? status : r.result;
      end
      if (cs_rise) begin
         next_r.oe = 1'b0;
      end
      case (r.st)
         ST_STRAP: begin
            next_r.strap_cnt = r.strap_cnt + 2'h1;
            if (r.strap_cnt == STRAP_WAIT) begin
               next_r.par = s_par;
               next_r.src = ppc_src_t'({s_hi, s_lo});
               // Memory enable idles high so that boot makes a falling edge
               next_r.hs  = !s_par && {s_hi, s_lo} == SRC_EPROM;
               next_r.st  = ST_BOOT;
            end
         end
         ST_BOOT, ST_IDLE: begin
            if (!r.par) begin
               next_r.st      = ST_LOAD;
               next_r.cfg_cnt = 16'h0000;
               next_r.hs      = (r.src == SRC_DSP);
            end else if (cs_rise && !s_rnw && s_rs
                         && r.bus_q == INSTR_CONFIGURE) begin
               next_r.st      = ST_LOAD;
               next_r.cfg_cnt = 16'h0000;
            end
         end
         ST_LOAD: begin
            if ((r.par && cs_rise && !s_rnw && !s_rs)
                || (!r.par && r.src[1])
                || (!r.par && !r.src[1] && bit_take)) begin
               next_r.cfg_cnt = r.cfg_cnt + 16'h0001;
               if (last_cfg) begin
                  next_r.done    = 1'b1;
                  next_r.partial = 1'b0;
                  next_r.st      = r.par ? ST_READY : ST_RUN;
                  if (!r.par) begin
                     next_r.hs = 1'b1;
                     if (r.src[1]) begin
                        next_r.hs_cnt = ROM_PULSE_CYCLES;
                     end
                  end
               end
            end
         end
         ST_READY: begin
            if (cs_rise && !s_rnw && s_rs && r.bus_q == INSTR_START) begin
               next_r.st = ST_RUN;
            end
         end
         ST_RUN: begin
            next_r.seq_cnt = r.seq_cnt + 16'h0001;
            if (r.seq_cnt == 16'(DECIM - 1)) begin
               next_r.seq_cnt = 16'h0000;
               next_r.result  = r.result + 16'h0001;
               if (r.settle != 8'h00) begin
                  next_r.settle = r.settle - 8'h01;
               end else begin
                  next_r.res_valid = 1'b1;
               end
            end
         end
         ST_LOW_POWER_REQUEST: begin
            if (!s_lp) begin
               if (r.done) begin
                  next_r.st = r.par ? ST_READY : ST_RUN;
               end else begin
                  next_r.st = ST_BOOT;
               end
            end
         end
         default: begin
            next_r.st = ST_STRAP;
         end
      endcase
      if (s_restart) begin
         next_r.seq_cnt   = 16'h0000;
         next_r.settle    = SETTLE_RESULTS;
         next_r.res_valid = 1'b0;
      end
      if (cfg_rst && r.st != ST_STRAP) begin
         next_r.done   = 1'b0;
         next_r.st     = ST_BOOT;
         next_r.hs_cnt = 4'h0;
      end
      if (s_lp && r.st != ST_STRAP && r.st != ST_LOW_POWER_REQUEST) begin
         next_r.st      = ST_LOW_POWER_REQUEST;
         next_r.partial = (r.st == ST_LOAD);
         next_r.hs_cnt  = 4'h0;
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         r        <= '0;
         r.st     <= ST_STRAP;
         r.cs_q   <= 1'b1;
         r.rst_q  <= 1'b1;
         r.settle <= SETTLE_RESULTS;
      end else begin
         r <= next_r;
      end
   end

   // ==========================================================
   // Outputs
   assign link.config_handshake_out = r.hs & ~r.par;
   assign link.config_done_flag     = r.done & ~r.par;
   assign link.dev_dout             = r.rdata;
   assign link.dev_oe               = r.oe;
   assign o_result                  = r.result;
   assign o_result_valid            = r.res_valid;
   assign o_configured              = r.done;
   assign o_low_power               = (r.st == ST_LOW_POWER_REQUEST);
   assign o_core_reset              = r.core_rst;
endmodule // ppc_device

// file: ppc_host.sv
// Purpose: Host end: parallel bus master, serial config source, pins.
// Assumes: One clock shared with the device clock source.
// Notes:   Config bit stream is a simple alternating pattern.
`timescale 1ns/1ps
module ppc_host
   import ppc_pkg::*;
#(
   parameter int CFG_BITS = ppc_pkg::CFG_BITS_DEF
) (
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset_n,
   ppc_link_if.host         link,
   input  wire logic        i_lp_req,
   input  wire logic        i_filter_restart,
   input  wire logic        i_cfg_restart,
   input  wire logic [1:0]  i_src_sel,
   input  wire logic        i_par_mode,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   input  wire logic        i_rs,
   input  wire logic [15:0] i_wdata,
   output      logic [15:0] o_rdata,
   output      logic        o_rdata_valid,
   output      logic        o_busy,
   output      logic        o_need_configure,
   output      logic        o_handshake
);
   import ppc_pkg::*;
   typedef struct packed {
      logic        cs_act;
      logic [3:0]  cs_cnt;
      logic        rnw;
      logic        rs;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic        rvalid;
      logic        need_cfg;
      logic        lp_q;
      logic        restart;
      logic [7:0]  gap;
      logic [3:0]  rst_cnt;
      logic        hs_q;
      logic        fsync;
      logic        feed;
      logic [15:0] bit_cnt;
      logic [3:0]  ph;
      logic        strobe;
   } ppc_host_regs_t;

   ppc_host_regs_t r;
   ppc_host_regs_t next_r;
   logic           s_hs;
   logic           take;

   // ==========================================================
   // Handshake synchroniser
   ppc_sync2 #(.W(1), .INIT(1'b0)) u_sync (
      .i_clk_sys (i_clk_sys),
      .i_reset_n (i_reset_n),
      .i_async   (link.config_handshake_out),
      .o_sync    (s_hs)
   );

   // Data writes refused while a configure instruction is owed
   assign take = (i_wr || i_rd) && !r.cs_act
               && !(i_wr && !i_rs && r.need_cfg);

   always_comb begin
      next_r        = r;
      next_r.rvalid = 1'b0;
      next_r.fsync  = 1'b0;
      next_r.lp_q   = i_lp_req;
      next_r.hs_q   = s_hs;
      if (r.lp_q && !i_lp_req && i_par_mode) begin
         next_r.need_cfg = 1'b1;
      end
      if (take) begin
         next_r.cs_act = 1'b1;
         next_r.cs_cnt = CS_LOW_CYCLES;
         next_r.rnw    = i_rd;
         next_r.rs     = i_rs;
         next_r.wdata  = i_wdata;
      end else if (r.cs_act) begin
         next_r.cs_cnt = r.cs_cnt - 4'h1;
         if (r.cs_cnt == 4'h1) begin
            next_r.cs_act = 1'b0;
            next_r.rvalid = r.rnw;
            next_r.rdata  = link.bus;
            if (!r.rnw && r.rs && r.wdata == INSTR_CONFIGURE) begin
               next_r.need_cfg = 1'b0;
            end
         end
      end
      // Restart pulses spaced by a quiet gap
      if (r.gap != 8'h00) begin
         next_r.gap = r.gap - 8'h01;
      end
      if (r.restart && !i_filter_restart) begin
         next_r.restart = 1'b0;
         next_r.gap     = RESTART_GAP;
      end else if (!r.restart && i_filter_restart && r.gap == 8'h00) begin
         next_r.restart = 1'b1;
      end
      if (r.rst_cnt != 4'h0) begin
         next_r.rst_cnt = r.rst_cnt - 4'h1;
      end else if (i_cfg_restart) begin
         next_r.rst_cnt = CFG_RST_CYCLES;
      end
      // Serial config source: DSP on handshake rise, EPROM on enable low
      // A fresh ready edge restarts the stream, even in mid-feed
      if (!i_par_mode && i_src_sel == SRC_DSP && s_hs && !r.hs_q) begin
         next_r.fsync   = 1'b1;
         next_r.feed    = 1'b1;
         next_r.bit_cnt = 16'h0000;
         next_r.ph      = 4'h0;
         next_r.strobe  = 1'b0;
      end else if (!i_par_mode && i_src_sel == SRC_EPROM && !s_hs
                   && r.hs_q) begin
         next_r.feed    = 1'b1;
         next_r.bit_cnt = 16'h0000;
         next_r.ph      = 4'h0;
         next_r.strobe  = 1'b0;
      end else if (r.feed) begin
         next_r.ph = r.ph + 4'h1;
         if (r.ph == BIT_HALF_CYCLES) begin
            next_r.ph     = 4'h0;
            next_r.strobe = ~r.strobe;
            if (r.strobe) begin
               next_r.bit_cnt = r.bit_cnt + 16'h0001;
               if (r.bit_cnt == 16'(CFG_BITS - 1)) begin
                  next_r.feed = 1'b0;
               end
            end
         end
      end
   end

   // ==========================================================
   // State register; clock never gated, runs through standby
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // ==========================================================
   // Pins and user outputs
   assign link.low_power_request    = i_lp_req;
   assign link.filter_restart       = r.restart;
   assign link.config_restart_pin_n = (r.rst_cnt == 4'h0);
   assign link.frame_sync_in        = r.fsync;
   assign link.select_n             = ~r.cs_act;
   assign link.read_not_write       = r.rnw;
   assign link.register_select_in   = r.rs;
   assign link.source_select_hi     = i_src_sel[1];
   assign link.source_select_lo     = i_src_sel[0];
   assign link.parallel_mode        = i_par_mode;
   assign link.cfg_bit              = r.bit_cnt[0];
   assign link.cfg_strobe           = r.strobe;
   assign link.host_dout            = r.wdata;
   assign link.host_oe              = r.cs_act & ~r.rnw;
   assign o_rdata                   = r.rdata;
   assign o_rdata_valid             = r.rvalid;
   assign o_busy                    = r.cs_act;
   assign o_need_configure          = r.need_cfg;
   assign o_handshake               = s_hs;
endmodule // ppc_host

// file: ppc_asserts.sv
// Purpose: Link wire checks between the converter end and the host end.
// Assumes: Straps steady from reset; source code is {hi, lo}.
// Notes:   Sees the link signals only.
`timescale 1ns/1ps
module ppc_asserts (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic parallel_mode,
   input wire logic source_select_hi,
   input wire logic source_select_lo,
   input wire logic low_power_request,
   input wire logic frame_sync_in,
   input wire logic config_restart_pin_n,
   input wire logic config_handshake_out,
   input wire logic config_done_flag,
   input wire logic select_n,
   input wire logic read_not_write,
   input wire logic dev_oe
);
   import ppc_pkg::*;
   logic [1:0] src;
   logic       dsp;
   logic       rom;
   logic       epr;
   assign src = {source_select_hi, source_select_lo};
   assign dsp = !parallel_mode && src == SRC_DSP;
   assign rom = !parallel_mode && src[1];
   assign epr = !parallel_mode && src == SRC_EPROM;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);
   // ==========================================================
   // Serial configuration handshake
   a_fsync_clears: assert property (
      dsp && $rose(frame_sync_in) |-> ##[1:5] !config_handshake_out)
      else $error("handshake not cleared by frame sync");
   a_rom_pulse: assert property (
      rom && $rose(config_handshake_out) |->
      config_handshake_out [*8] ##1 !config_handshake_out)
      else $error("boot pulse not eight cycles");
   a_eprom_done: assert property (
      epr && $rose(config_done_flag) |-> ##[0:2] config_handshake_out)
      else $error("memory enable not released after load");
   a_dsp_done: assert property (
      dsp && $rose(config_done_flag) |-> ##[0:2] config_handshake_out)
      else $error("handshake not raised after load");
   a_boot_ready: assert property (
      $rose(i_reset_n) ##2 dsp |-> ##[1:24] config_handshake_out)
      else $error("handshake not raised after reset");
   a_restart_ready: assert property (
      dsp && $fell(config_restart_pin_n) |-> ##[1:12] config_handshake_out)
      else $error("handshake not raised after config restart");
   a_standby_keep: assert property (
      !parallel_mode && low_power_request && config_done_flag
      |=> config_done_flag)
      else $error("configuration lost in standby");
   // ==========================================================
   // Parallel mode: serial flags quiet, bus driven on read
   a_par_quiet: assert property (
      parallel_mode |-> !config_done_flag && !config_handshake_out)
      else $error("serial flags active in parallel mode");
   a_read_drive: assert property (
      parallel_mode && read_not_write && $fell(select_n) |-> ##[2:4] dev_oe)
      else $error("bus not driven on read");
endmodule // ppc_asserts

// file: postproc_config_control_test.sv
// Purpose: Self-checking bench for both ends joined by the link.
// Assumes: Short counts: 8 bits, 2 words, 4 ROM cycles, decimation 4.
// Notes:   Serial modes run from a row table, the rest by hand.
`timescale 1ns/1ps
module postproc_config_control_test;
   import ppc_pkg::*;
   typedef struct packed {logic [1:0] s; logic hs;} ppc_row_t;
   logic        i_clk_sys = 1'b0;
   logic        i_reset_n = 1'b0;
   logic        lp = 1'b0, fr = 1'b0, cr = 1'b0, par = 1'b0;
   logic        wr = 1'b0, rd = 1'b0, rs = 1'b0;
   logic [1:0]  src = 2'h0;
   logic [15:0] wdata = 16'h0000;
   logic [15:0] rdata;
   logic        busy, need_cfg, res_v, cfgd, low_pw, core_rst, seen;
   int          fail_count = 0;
   int          checked = 0;
   int          cycles = 0;
   ppc_row_t    rows [4] = '{'{2'h0, 1'b1}, '{2'h1, 1'b0},
                             '{2'h2, 1'b0}, '{2'h3, 1'b0}};
   always #5 i_clk_sys = ~i_clk_sys;
   ppc_link_if ppc_link_if_i ();
   ppc_device #(.CFG_BITS(8), .CFG_WORDS(2), .ROM_LEN(4), .DECIM(4))
      ppc_device_i (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
      .link(ppc_link_if_i.dev), .o_result(), .o_result_valid(res_v),
      .o_configured(cfgd), .o_low_power(low_pw), .o_core_reset(core_rst));
   ppc_host #(.CFG_BITS(8)) ppc_host_i (.i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n), .link(ppc_link_if_i.host), .i_lp_req(lp),
      .i_filter_restart(fr), .i_cfg_restart(cr), .i_src_sel(src),
      .i_par_mode(par), .i_wr(wr), .i_rd(rd), .i_rs(rs), .i_wdata(wdata),
      .o_rdata(rdata), .o_rdata_valid(), .o_busy(busy),
      .o_need_configure(need_cfg), .o_handshake());
   ppc_asserts ppc_asserts_i (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
      .parallel_mode(ppc_link_if_i.parallel_mode),
      .source_select_hi(ppc_link_if_i.source_select_hi),
      .source_select_lo(ppc_link_if_i.source_select_lo),
      .low_power_request(ppc_link_if_i.low_power_request),
      .frame_sync_in(ppc_link_if_i.frame_sync_in),
      .config_restart_pin_n(ppc_link_if_i.config_restart_pin_n),
      .config_handshake_out(ppc_link_if_i.config_handshake_out),
      .config_done_flag(ppc_link_if_i.config_done_flag),
      .select_n(ppc_link_if_i.select_n),
      .read_not_write(ppc_link_if_i.read_not_write),
      .dev_oe(ppc_link_if_i.dev_oe));
   // ==========================================================
   // Checking and closing
   task automatic check_bit(string name, logic exp, logic got);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge i_clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         test_done();
      end
   end
   // ==========================================================
   // Drivers
   task automatic boot(logic [1:0] s, logic p);
      @(posedge i_clk_sys);
      i_reset_n <= 1'b0;
      src <= s;
      par <= p;
      repeat (4) @(posedge i_clk_sys);
      i_reset_n <= 1'b1;
   endtask
   task automatic wait_on(ref logic sig, input logic v, input int n);
      for (int k = 0; k < n && sig !== v; k++) @(negedge i_clk_sys);
   endtask
   task automatic acc(logic w, logic r_s, logic [15:0] d);
      @(posedge i_clk_sys);
      wr <= w;
      rd <= !w;
      rs <= r_s;
      wdata <= d;
      @(posedge i_clk_sys);
      wr <= 1'b0;
      rd <= 1'b0;
      @(negedge i_clk_sys);
      for (int k = 0; k < 20 && busy === 1'b1; k++) @(negedge i_clk_sys);
      repeat (3) @(negedge i_clk_sys);
   endtask
   task automatic standby(int n);
      @(posedge i_clk_sys) lp <= 1'b1;
      repeat (n) @(negedge i_clk_sys);
      @(posedge i_clk_sys) lp <= 1'b0;
      repeat (n) @(negedge i_clk_sys);
   endtask
   // ==========================================================
   // Scenarios
   initial begin
      foreach (rows[i]) begin
         boot(rows[i].s, 1'b0);
         wait_on(cfgd, 1'b1, 600);
         check_bit("configured", 1'b1, cfgd);
         check_bit("done flag", 1'b1, ppc_link_if_i.config_done_flag);
         repeat (2) @(negedge i_clk_sys);
         check_bit("hs raised", 1'b1,
                   ppc_link_if_i.config_handshake_out);
         repeat (12) @(negedge i_clk_sys);
         check_bit("handshake", rows[i].hs,
                   ppc_link_if_i.config_handshake_out);
         wait_on(res_v, 1'b1, 200);
         check_bit("result", 1'b1, res_v);
      end
      boot(2'h1, 1'b0);
      wait_on(cfgd, 1'b1, 600);
      @(posedge i_clk_sys) lp <= 1'b1;
      repeat (10) @(negedge i_clk_sys);
      check_bit("low power", 1'b1, low_pw);
      check_bit("kept config", 1'b1, cfgd);
      @(posedge i_clk_sys) lp <= 1'b0;
      repeat (10) @(negedge i_clk_sys);
      check_bit("awake", 1'b0, low_pw);
      wait_on(res_v, 1'b1, 200);
      check_bit("resumed", 1'b1, res_v);
      @(posedge i_clk_sys) cr <= 1'b1;
      @(posedge i_clk_sys) cr <= 1'b0;
      repeat (300) @(negedge i_clk_sys);
      check_bit("reloaded", 1'b1, ppc_link_if_i.config_done_flag);
      @(posedge i_clk_sys) fr <= 1'b1;
      repeat (8) @(negedge i_clk_sys);
      check_bit("core reset", 1'b1, core_rst);
      @(posedge i_clk_sys) fr <= 1'b0;
      wait_on(core_rst, 1'b0, 10);
      seen = 1'b0;
      repeat (12) @(negedge i_clk_sys) seen |= res_v;
      check_bit("early result", 1'b0, seen);
      wait_on(res_v, 1'b1, 100);
      check_bit("settled result", 1'b1, res_v);
      boot(2'h1, 1'b0);
      repeat (40) @(negedge i_clk_sys);
      @(posedge i_clk_sys) lp <= 1'b1;
      repeat (10) @(negedge i_clk_sys);
      check_bit("partial kept", 1'b0, cfgd);
      @(posedge i_clk_sys) lp <= 1'b0;
      wait_on(cfgd, 1'b1, 600);
      check_bit("reconfigured", 1'b1, cfgd);
      boot(2'h0, 1'b1);
      repeat (20) @(negedge i_clk_sys);
      acc(1'b0, 1'b1, 16'h0000);
      check_bit("status par", 1'b1, rdata[STAT_PAR]);
      acc(1'b1, 1'b1, INSTR_CONFIGURE);
      acc(1'b1, 1'b0, 16'h5a3c);
      standby(10);
      check_bit("need configure", 1'b1, need_cfg);
      acc(1'b1, 1'b1, INSTR_CONFIGURE);
      acc(1'b1, 1'b0, 16'h00ff);
      acc(1'b1, 1'b0, 16'hff00);
      acc(1'b0, 1'b1, 16'h0000);
      check_bit("status done", 1'b1, rdata[STAT_DONE]);
      standby(10);
      acc(1'b0, 1'b1, 16'h0000);
      check_bit("held idle", 1'b0, rdata[STAT_RUN]);
      acc(1'b1, 1'b1, INSTR_START);
      acc(1'b0, 1'b1, 16'h0000);
      check_bit("started", 1'b1, rdata[STAT_RUN]);
      test_done();
   end
endmodule // postproc_config_control_test
